// ===== flc_core.sv
//////////////////////////////////////////////////////////////////////////////
module flc_core #(
  parameter int PAGE_WRITE_CYC   = flc_pkg::PAGE_WRITE_CYC,
  parameter int CONFIG_WRITE_CYC = flc_pkg::CONFIG_WRITE_CYC,
  parameter int BLOCK_WIPE_CYC   = flc_pkg::BLOCK_WIPE_CYC,
  parameter int FULL_WIPE_CYC    = flc_pkg::FULL_WIPE_CYC
) (
  input  wire logic                      clk_i,
  input  wire logic                      srst_i,
  input  wire logic                      sclk_i,
  input  wire logic                      cs_n_i,
  input  wire logic                      si_i,
  input  wire logic                      hold_n_i,
  input  wire logic                      wp_n_i,
  input  wire logic [flc_pkg::ADDR_W-1:0] peek_addr_i,
  output logic                           so_o,
  output logic                           so_oe_o,
  output logic                           busy_o,
  output logic                           active_o,
  output logic      [7:0]                status_o,
  output logic      [7:0]                peek_data_o
);
  import flc_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic       lk_clr_ff;
  logic [2:0] lk_cnt_ff, nxt_lk_cnt;
  logic [7:0] lk_opc_ff, nxt_lk_opc;
  logic       lk_rd_ff, nxt_lk_rd;
  logic       lk_bit_ff, nxt_lk_bit;
  logic       lk_tgl_ff, nxt_lk_tgl;
  logic       lk_hold_ff, nxt_lk_hold;
  logic       so_ff, nxt_so;
  logic [7:0] stat_lk;
  logic       paused;

  logic       cs_s, wp_n_s, tgl_s, bit_s;
  logic       cs_d_ff, nxt_cs_d;
  logic       tgl_d1_ff, nxt_tgl_d1;
  logic       tgl_d2_ff, nxt_tgl_d2;
  logic       in_frame_ff, nxt_in_frame;
  logic [2:0] drain_ff, nxt_drain;
  logic       ign_ff, nxt_ign;
  logic [2:0] bcnt_ff, nxt_bcnt;
  logic [7:0] shf_ff, nxt_shf;
  flc_phase_t phase_ff, nxt_phase;
  logic [7:0] opc_ff, nxt_opc;
  logic [15:0] addr_ff, nxt_addr;
  logic [1:0] acnt_ff, nxt_acnt;
  logic [8:0] dcnt_ff, nxt_dcnt;
  logic [7:0] cfg_ff, nxt_cfg;
  logic       cs_fall, cs_rise, bit_ev, byte_ev, frame_end, upd_ok;
  logic [7:0] byte_val;

  flc_op_t    op_ff, nxt_op;
  logic [15:0] walk_ff, nxt_walk;
  logic       ph_ff, nxt_ph;
  logic [31:0] timer_ff, nxt_timer;
  logic       unlock_ff, nxt_unlock;
  logic [1:0] bp_ff, nxt_bp;
  logic       full_ff, nxt_full;
  logic       busy, eval_ok, prot_hit;
  logic [8:0] pg_n;

  flc_mem_if #(.AW(ADDR_W))     arr_if ();
  flc_mem_if #(.AW(PAGE_OFS_W)) pbuf_if ();

  //////////////////////////////////////////////////////////////////////////////
  // Link side: serial clock domain

  always_comb
  begin
    nxt_lk_cnt = lk_cnt_ff;
    nxt_lk_opc = lk_opc_ff;
    nxt_lk_rd  = lk_rd_ff;
    nxt_lk_bit = lk_bit_ff;
    nxt_lk_tgl = lk_tgl_ff;
    // Pause level as seen while clock low
    nxt_lk_hold = ~hold_n_i;
    if (hold_n_i)
    begin
      nxt_lk_cnt = lk_cnt_ff + 3'h1;
      nxt_lk_bit = si_i;
      nxt_lk_tgl = ~lk_tgl_ff;
      if (!lk_rd_ff)
      begin
        nxt_lk_opc = {lk_opc_ff[6:0], si_i};
      end
      if ((lk_cnt_ff == 3'h7) && !lk_rd_ff)
      begin
        nxt_lk_rd = ({lk_opc_ff[6:0], si_i} == OPC_STATUS_READ);
      end
    end
  end

  always_ff @(posedge sclk_i or posedge cs_n_i)
  begin
    if (cs_n_i)
    begin
      lk_cnt_ff  <= 3'h0;
      lk_opc_ff  <= 8'h00;
      lk_rd_ff   <= 1'b0;
      lk_hold_ff <= 1'b0;
    end
    else
    begin
      lk_cnt_ff  <= nxt_lk_cnt;
      lk_opc_ff  <= nxt_lk_opc;
      lk_rd_ff   <= nxt_lk_rd;
      lk_hold_ff <= nxt_lk_hold;
    end
  end

  // Bit toggle survives deselect so the core never sees a false event
  always_ff @(posedge sclk_i or posedge lk_clr_ff)
  begin
    if (lk_clr_ff)
    begin
      lk_bit_ff <= 1'b0;
      lk_tgl_ff <= 1'b0;
    end
    else
    begin
      lk_bit_ff <= nxt_lk_bit;
      lk_tgl_ff <= nxt_lk_tgl;
    end
  end

  always_comb
  begin
    nxt_so      = so_ff;
    if (hold_n_i)
    begin
      nxt_so = stat_lk[~lk_cnt_ff];
    end
  end

  always_ff @(negedge sclk_i or posedge cs_n_i)
  begin
    if (cs_n_i)
    begin
      so_ff      <= 1'b0;
    end
    else
    begin
      so_ff      <= nxt_so;
    end
  end

  // Status crosses as independent level flags
  flc_sync #(.W(8)) u_stat_sync (
    .clk_i (sclk_i),
    .d_i   (status_o),
    .q_o   (stat_lk)
  );

  assign paused  = sclk_i ? lk_hold_ff : ~hold_n_i;
  assign so_o    = so_ff;
  assign so_oe_o = lk_rd_ff & ~cs_n_i & ~paused;

  //////////////////////////////////////////////////////////////////////////////
  // Core side: frame decode on the system clock

  flc_sync #(.W(4)) u_in_sync (
    .clk_i (clk_i),
    .d_i   ({cs_n_i, wp_n_i, lk_tgl_ff, lk_bit_ff}),
    .q_o   ({cs_s, wp_n_s, tgl_s, bit_s})
  );

  // Cleared low so a select already low at release is no edge
  assign cs_fall   = cs_d_ff & ~cs_s;
  assign cs_rise   = ~cs_d_ff & cs_s;
  assign bit_ev    = in_frame_ff & (tgl_d1_ff != tgl_d2_ff);
  assign byte_ev   = bit_ev & (bcnt_ff == 3'h7);
  assign byte_val  = {shf_ff[6:0], bit_s};
  assign frame_end = (drain_ff == 3'h1);
  assign upd_ok    = ~ign_ff & ~busy;

  // Byte assembly and header decode
  always_comb
  begin
    nxt_cs_d     = cs_s;
    nxt_tgl_d1   = tgl_s;
    nxt_tgl_d2   = tgl_d1_ff;
    nxt_in_frame = in_frame_ff;
    nxt_drain    = drain_ff;
    nxt_ign      = ign_ff | busy;
    nxt_bcnt     = bcnt_ff;
    nxt_shf      = shf_ff;
    nxt_phase    = phase_ff;
    nxt_opc      = opc_ff;
    nxt_addr     = addr_ff;
    nxt_acnt     = acnt_ff;
    nxt_dcnt     = dcnt_ff;
    nxt_cfg      = cfg_ff;
    if (drain_ff != 3'h0)
    begin
      nxt_drain = drain_ff - 3'h1;
      if (frame_end)
      begin
        nxt_in_frame = 1'b0;
      end
    end
    if (cs_rise && in_frame_ff)
    begin
      nxt_drain = FRAME_DRAIN_CYC;
    end
    if (bit_ev)
    begin
      nxt_bcnt = bcnt_ff + 3'h1;
      nxt_shf  = byte_val;
    end
    if (byte_ev)
    begin
      case (phase_ff)
        PH_OPC:
        begin
          nxt_opc = byte_val;
          if ((byte_val == OPC_PAGE_WRITE) || (byte_val == OPC_BLOCK_WIPE))
          begin
            nxt_phase = PH_ADDR;
          end
          else if (byte_val == OPC_CONFIG_WRITE)
          begin
            nxt_phase = PH_DATA;
          end
          else
          begin
            nxt_phase = PH_SKIP;
          end
        end
        PH_ADDR:
        begin
          if (upd_ok)
          begin
            nxt_addr = {addr_ff[7:0], byte_val};
            nxt_acnt = acnt_ff + 2'h1;
          end
          if (acnt_ff == ADDR_BYTES_LAST)
          begin
            nxt_phase = (opc_ff == OPC_PAGE_WRITE) ? PH_DATA : PH_SKIP;
          end
        end
        PH_DATA:
        begin
          if (upd_ok)
          begin
            if (dcnt_ff == 9'h000)
            begin
              nxt_cfg = byte_val;
            end
            if (dcnt_ff != PAGE_BYTES)
            begin
              nxt_dcnt = dcnt_ff + 9'h001;
            end
          end
        end
        default:
        begin
          nxt_phase = PH_SKIP;
        end
      endcase
    end
    // Each select fall arms the core
    if (cs_fall)
    begin
      nxt_in_frame = 1'b1;
      nxt_drain    = 3'h0;
      nxt_ign      = busy;
      nxt_bcnt     = 3'h0;
      nxt_phase    = PH_OPC;
      if (!busy)
      begin
        nxt_addr = 16'h0000;
        nxt_acnt = 2'h0;
        nxt_dcnt = 9'h000;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    lk_clr_ff <= srst_i;
    if (srst_i)
    begin
      cs_d_ff     <= 1'b0;
      tgl_d1_ff   <= 1'b0;
      tgl_d2_ff   <= 1'b0;
      in_frame_ff <= 1'b0;
      drain_ff    <= 3'h0;
      ign_ff      <= 1'b0;
      bcnt_ff     <= 3'h0;
      shf_ff      <= 8'h00;
      phase_ff    <= PH_OPC;
      opc_ff      <= 8'h00;
      addr_ff     <= 16'h0000;
      acnt_ff     <= 2'h0;
      dcnt_ff     <= 9'h000;
      cfg_ff      <= 8'h00;
    end
    else
    begin
      cs_d_ff     <= nxt_cs_d;
      tgl_d1_ff   <= nxt_tgl_d1;
      tgl_d2_ff   <= nxt_tgl_d2;
      in_frame_ff <= nxt_in_frame;
      drain_ff    <= nxt_drain;
      ign_ff      <= nxt_ign;
      bcnt_ff     <= nxt_bcnt;
      shf_ff      <= nxt_shf;
      phase_ff    <= nxt_phase;
      opc_ff      <= nxt_opc;
      addr_ff     <= nxt_addr;
      acnt_ff     <= nxt_acnt;
      dcnt_ff     <= nxt_dcnt;
      cfg_ff      <= nxt_cfg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Core side: internal write cycles

  assign busy     = (op_ff != ST_IDLE);
  assign eval_ok  = frame_end & upd_ok & (bcnt_ff == 3'h0);
  assign prot_hit = (bp_ff == PROT_NONE) ? 1'b0 :
                    (bp_ff == PROT_UPPER) ? addr_ff[SECTOR_BIT] : 1'b1;
  assign pg_n     = (dcnt_ff > PAGE_BYTES) ? PAGE_BYTES : dcnt_ff;

  always_comb
  begin
    nxt_op     = op_ff;
    nxt_walk   = walk_ff;
    nxt_ph     = ph_ff;
    nxt_timer  = (timer_ff != 32'h0) ? timer_ff - 32'h1 : timer_ff;
    nxt_unlock = unlock_ff;
    nxt_bp     = bp_ff;
    nxt_full   = full_ff;
    case (op_ff)
      ST_IDLE:
      begin
        nxt_walk = 16'h0000;
        nxt_ph   = 1'b0;
        if (eval_ok && (opc_ff == OPC_WRITE_UNLOCK))
        begin
          nxt_unlock = 1'b1;
        end
        else if (eval_ok && unlock_ff)
        begin
          if ((opc_ff == OPC_PAGE_WRITE) && (phase_ff == PH_DATA) && (dcnt_ff != 9'h000))
          begin
            nxt_unlock = 1'b0;
            if (!prot_hit)
            begin
              nxt_op    = ST_PROG;
              nxt_timer = 32'(PAGE_WRITE_CYC);
            end
          end
          else if ((opc_ff == OPC_BLOCK_WIPE) && (phase_ff == PH_SKIP))
          begin
            nxt_unlock = 1'b0;
            if (!prot_hit)
            begin
              nxt_op    = ST_ERASE;
              nxt_full  = 1'b0;
              nxt_timer = 32'(BLOCK_WIPE_CYC);
            end
          end
          else if (opc_ff == OPC_FULL_WIPE)
          begin
            nxt_unlock = 1'b0;
            if (bp_ff == PROT_NONE)
            begin
              nxt_op    = ST_ERASE;
              nxt_full  = 1'b1;
              nxt_timer = 32'(FULL_WIPE_CYC);
            end
          end
          else if ((opc_ff == OPC_CONFIG_WRITE) && (dcnt_ff != 9'h000))
          begin
            nxt_unlock = 1'b0;
            nxt_op     = ST_WAIT;
            nxt_timer  = 32'(CONFIG_WRITE_CYC);
            if (wp_n_s)
            begin
              nxt_bp = {cfg_ff[STAT_PROT_HI_BIT], cfg_ff[STAT_PROT_LO_BIT]};
            end
          end
        end
      end
      ST_PROG:
      begin
        nxt_ph = ~ph_ff;
        if (ph_ff)
        begin
          nxt_walk = walk_ff + 16'h0001;
          if (walk_ff[8:0] == pg_n - 9'h001)
          begin
            nxt_op = ST_WAIT;
          end
        end
      end
      ST_ERASE:
      begin
        nxt_walk = walk_ff + 16'h0001;
        if (full_ff ? (walk_ff == 16'hffff) : (walk_ff[14:0] == 15'h7fff))
        begin
          nxt_op = ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        if (timer_ff == 32'h0)
        begin
          nxt_op = ST_IDLE;
        end
      end
      default:
      begin
        nxt_op = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      op_ff     <= ST_IDLE;
      walk_ff   <= 16'h0000;
      ph_ff     <= 1'b0;
      timer_ff  <= 32'h0;
      unlock_ff <= 1'b0;
      bp_ff     <= PROTECT_RST;
      full_ff   <= 1'b0;
    end
    else
    begin
      op_ff     <= nxt_op;
      walk_ff   <= nxt_walk;
      ph_ff     <= nxt_ph;
      timer_ff  <= nxt_timer;
      unlock_ff <= nxt_unlock;
      bp_ff     <= nxt_bp;
      full_ff   <= nxt_full;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Array and page buffer ports

  assign arr_if.addr  = (op_ff == ST_PROG) ? {addr_ff[15:8], addr_ff[7:0] + walk_ff[7:0]} :
                        (op_ff != ST_ERASE) ? peek_addr_i :
                        full_ff ? walk_ff : {addr_ff[SECTOR_BIT], walk_ff[14:0]};
  assign arr_if.we    = ((op_ff == ST_PROG) & ph_ff) | (op_ff == ST_ERASE);
  assign arr_if.wdata = (op_ff == ST_PROG) ? (arr_if.rdata & pbuf_if.rdata) : ERASED_BYTE;

  // Offsets wrap inside the page; from the 257th byte on all land on the start offset, later bytes win
  assign pbuf_if.addr  = addr_ff[7:0] + (busy ? walk_ff[7:0] : dcnt_ff[7:0]);
  assign pbuf_if.we    = byte_ev & upd_ok & (phase_ff == PH_DATA) & (opc_ff == OPC_PAGE_WRITE);
  assign pbuf_if.wdata = byte_val;

  flc_mem #(.AW(ADDR_W)) u_array (
    .clk_i    (clk_i),
    .mem_port (arr_if.mem)
  );

  flc_mem #(.AW(PAGE_OFS_W)) u_page_buf (
    .clk_i    (clk_i),
    .mem_port (pbuf_if.mem)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Status and outputs
  always_comb
  begin
    status_o                   = 8'h00;
    status_o[STAT_BUSY_BIT]    = busy;
    status_o[STAT_UNLOCK_BIT]  = unlock_ff;
    status_o[STAT_PROT_LO_BIT] = bp_ff[0];
    status_o[STAT_PROT_HI_BIT] = bp_ff[1];
  end

  assign busy_o      = busy;
  assign active_o    = ~cs_s | busy;
  assign peek_data_o = arr_if.rdata;

endmodule

// ===== flc_core_monitor.sv
module flc_core_monitor #(
  parameter int CFG_CYC = 20
) (
  input wire logic       clk_i,
  input wire logic       srst_i,
  input wire logic       sclk_i,
  input wire logic       cs_n_i,
  input wire logic       hold_n_i,
  input wire logic       wp_n_i,
  input wire logic       so_o,
  input wire logic       so_oe_o,
  input wire logic       busy_o,
  input wire logic       active_o,
  input wire logic [7:0] status_o
);
  import flc_pkg::*;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);
  ////////////////////////////////////////
  // Length of the current busy stretch
  logic [31:0] busy_len_ff;
  logic [31:0] nxt_busy_len;
  always_comb nxt_busy_len = busy_o ? busy_len_ff + 32'h1 : 32'h0;
  always_ff @(posedge clk_i) busy_len_ff <= srst_i ? 32'h0 : nxt_busy_len;
  // Deselected or paused means a floating output
  chk_deselect_float: assert property (cs_n_i |-> !so_oe_o)
    else $error("output driven while deselected");
  chk_pause_float: assert property (!cs_n_i && !hold_n_i && !sclk_i |-> !so_oe_o)
    else $error("output driven while paused");
  // Output may only move just after a clock fall
  chk_so_on_fall: assert property (!cs_n_i && $changed(so_o) |-> !sclk_i)
    else $error("data out moved off a falling edge");
  chk_active_sel: assert property (!cs_n_i [*4] |-> active_o)
    else $error("selected but not active");
  chk_standby_idle: assert property ((cs_n_i && !busy_o) [*5] |-> !active_o)
    else $error("idle and deselected but still active");
  chk_busy_active: assert property (busy_o [*2] |-> active_o)
    else $error("standby during internal cycle");
  chk_busy_flag: assert property (busy_o [*2] |-> status_o[STAT_BUSY_BIT])
    else $error("busy flag clear during cycle");
  // Short cycles would mean the timer was skipped
  chk_busy_span: assert property ($fell(busy_o) |-> busy_len_ff >= CFG_CYC)
    else $error("internal cycle too short");
  chk_unlock_first: assert property ($rose(busy_o) |-> $past(status_o[1]) || $past(status_o[1], 2))
    else $error("cycle started without unlock");
  chk_protect_frozen: assert property (!wp_n_i && !$past(wp_n_i, 3) |-> $stable(status_o[3:2]))
    else $error("protect bits changed while write protected");
endmodule

bind flc_core flc_core_monitor #(.CFG_CYC(CONFIG_WRITE_CYC)) u_monitor (
  .clk_i    (clk_i),
  .srst_i   (srst_i),
  .sclk_i   (sclk_i),
  .cs_n_i   (cs_n_i),
  .hold_n_i (hold_n_i),
  .wp_n_i   (wp_n_i),
  .so_o     (so_o),
  .so_oe_o  (so_oe_o),
  .busy_o   (busy_o),
  .active_o (active_o),
  .status_o (status_o)
);

// ===== flc_core_test.sv
module flc_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  import flc_pkg::*;
  logic        clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        wp_n_i = 1'b1;
  logic [15:0] peek_addr_i = 16'h0000;
  logic        sclk, cs_n, si, hold_n, so, so_oe, busy, active;
  logic [7:0]  status, peek_data;
  int          fails = 0;
  int          num_checks = 0;
  always #5 clk_i = ~clk_i;
  ////////////////////////////////////////
  // Shortened timers keep the run small
  flc_core #(.PAGE_WRITE_CYC(600), .CONFIG_WRITE_CYC(20), .BLOCK_WIPE_CYC(33000)) DUT (
    .clk_i(clk_i), .srst_i(srst_i), .sclk_i(sclk), .cs_n_i(cs_n), .si_i(si), .hold_n_i(hold_n),
    .wp_n_i(wp_n_i), .peek_addr_i(peek_addr_i), .so_o(so), .so_oe_o(so_oe), .busy_o(busy),
    .active_o(active), .status_o(status), .peek_data_o(peek_data));
  flc_spi_host h (.sclk_o(sclk), .cs_n_o(cs_n), .si_o(si), .hold_n_o(hold_n), .so_i(so), .so_oe_i(so_oe));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected %0t %s", $time, what);
    end
  endtask
  task automatic results();
    if (fails == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic send(input logic [7:0] b[$], input int n_last = 8, input logic pol = 1'b0);
    h.open_frame(pol);
    foreach (b[i]) h.shift(b[i], (i == b.size() - 1) ? n_last : 8);
    h.close_frame();
    repeat (8) @(negedge clk_i);
  endtask
  task automatic unlock();
    send('{OPC_WRITE_UNLOCK});
  endtask
  // Bounded so a stuck busy cannot hang the run
  task automatic wait_idle();
    for (int i = 0; i < 40000 && busy !== 1'b0; i++) @(negedge clk_i);
    check({7'h0, busy}, 8'h00, "busy never cleared");
  endtask
  task automatic peek(input logic [15:0] a, input logic [7:0] e);
    @(negedge clk_i);
    peek_addr_i = a;
    repeat (2) @(negedge clk_i);
    check(peek_data, e, "array byte");
  endtask
  ////////////////////////////////////////
  // Locked wipe refused, then sector 0 wiped
  task automatic t_wipe();
    send('{OPC_BLOCK_WIPE, 8'h00, 8'h00, 8'h00});
    check({7'h0, busy}, 8'h00, "wipe ran locked");
    unlock();
    check({7'h0, status[STAT_UNLOCK_BIT]}, 8'h01, "unlock bit");
    send('{OPC_BLOCK_WIPE, 8'h00, 8'h40, 8'h00});
    check({7'h0, busy}, 8'h01, "wipe not busy");
    wait_idle();
    peek(16'h0000, ERASED_BYTE);
    peek(16'h7fff, ERASED_BYTE);
  endtask
  // Page wrap, paused status poll, and-only rewrite in mode 3
  task automatic t_page();
    logic [7:0] rd;
    unlock();
    send('{OPC_PAGE_WRITE, 8'h00, 8'h12, 8'hfe, 8'ha5, 8'h3c, 8'h0f});
    h.open_frame(1'b0);
    h.shift(OPC_STATUS_READ, 8);
    h.pause_toggle();
    h.shift(8'h00, 8);
    rd = h.rx;
    h.close_frame();
    check(rd, 8'h01, "status while busy");
    wait_idle();
    unlock();
    send('{OPC_PAGE_WRITE, 8'h00, 8'h12, 8'hfe, 8'hf0}, 8, 1'b1);
    wait_idle();
    peek(16'h12fe, 8'ha0);
    peek(16'h12ff, 8'h3c);
    peek(16'h1200, 8'h0f);
  endtask
  // Frame one bit short must be dropped
  task automatic t_odd();
    unlock();
    send('{OPC_PAGE_WRITE, 8'h00, 8'h30, 8'h00, 8'h00}, 7);
    check({7'h0, busy}, 8'h00, "short frame ran");
    check({7'h0, status[STAT_UNLOCK_BIT]}, 8'h01, "unlock lost");
  endtask
  // Protect bits set, frozen by pin, full wipe refused
  task automatic t_protect();
    unlock();
    send('{OPC_CONFIG_WRITE, 8'h04});
    wait_idle();
    check({6'h0, status[3:2]}, 8'h01, "protect not set");
    @(negedge clk_i);
    wp_n_i = 1'b0;
    unlock();
    send('{OPC_CONFIG_WRITE, 8'h0c});
    wait_idle();
    check({6'h0, status[3:2]}, 8'h01, "protect changed");
    unlock();
    send('{OPC_FULL_WIPE});
    check({7'h0, busy}, 8'h00, "full wipe ran protected");
    @(negedge clk_i);
    wp_n_i = 1'b1;
  endtask
  initial
  begin
    repeat (3) @(negedge clk_i);
    srst_i = 1'b0;
    repeat (4) @(negedge clk_i);
    h.open_frame(1'b0);
    h.close_frame();
    repeat (8) @(negedge clk_i);
    t_wipe();
    t_page();
    t_odd();
    t_protect();
    results();
  end
  // Wipe alone takes about a third of this span
  initial
  begin
    #1_000_000;
    fails++;
    results();
  end
endmodule

// ===== flc_mem.sv
module flc_mem #(
  parameter int AW = 16
) (
  input wire logic   clk_i,
  flc_mem_if.mem     mem_port
);

  logic [7:0] store [2**AW];

  // Read-first port, read data from a register
  always_ff @(posedge clk_i)
  begin
    if (mem_port.we)
    begin
      store[mem_port.addr] <= mem_port.wdata;
    end
    mem_port.rdata <= store[mem_port.addr];
  end

endmodule

// ===== flc_mem_if.sv
interface flc_mem_if #(parameter int AW = 16);
  logic          we;
  logic [AW-1:0] addr;
  logic [7:0]    wdata;
  logic [7:0]    rdata;
  modport ctrl (output we, output addr, output wdata, input rdata);
  modport mem  (input we, input addr, input wdata, output rdata);
endinterface

// ===== flc_pkg.sv
package flc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and cycle timing
  localparam int CLK_PERIOD_NS     = 10;
  localparam int T_PAGE_WRITE_NS   = 500_000;
  localparam int T_CONFIG_WRITE_NS = 100_000;
  localparam int T_BLOCK_WIPE_NS   = 2_000_000;
  localparam int T_FULL_WIPE_NS    = 4_000_000;
  // Least times, rounded up to whole cycles
  localparam int PAGE_WRITE_CYC    = (T_PAGE_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONFIG_WRITE_CYC  = (T_CONFIG_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLOCK_WIPE_CYC    = (T_BLOCK_WIPE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FULL_WIPE_CYC     = (T_FULL_WIPE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Lets the last bit toggle clear the synchroniser after deselect
  localparam logic [2:0] FRAME_DRAIN_CYC = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // Array geometry: 2 sectors x 128 pages x 256 bytes
  localparam int         ADDR_W          = 16;
  localparam int         PAGE_OFS_W      = 8;
  localparam int         SECTOR_BIT      = 15;
  localparam logic [1:0] ADDR_BYTES_LAST = 2'h2;
  localparam logic [8:0] PAGE_BYTES      = 9'h100;
  localparam logic [7:0] ERASED_BYTE     = 8'hff;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction codes
  localparam logic [7:0] OPC_WRITE_UNLOCK = 8'h11;
  localparam logic [7:0] OPC_PAGE_WRITE   = 8'h12;
  localparam logic [7:0] OPC_BLOCK_WIPE   = 8'h13;
  localparam logic [7:0] OPC_FULL_WIPE    = 8'h14;
  localparam logic [7:0] OPC_CONFIG_WRITE = 8'h15;
  localparam logic [7:0] OPC_STATUS_READ  = 8'h16;

  ////////////////////////////////////////////////////////////////////////////
  // Status byte layout and protect encodings
  localparam int         STAT_BUSY_BIT    = 0;
  localparam int         STAT_UNLOCK_BIT  = 1;
  localparam int         STAT_PROT_LO_BIT = 2;
  localparam int         STAT_PROT_HI_BIT = 3;
  localparam logic [1:0] PROTECT_RST      = 2'h0;
  localparam logic [1:0] PROT_NONE        = 2'h0;
  localparam logic [1:0] PROT_UPPER       = 2'h1;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_PROG  = 2'b01,
    ST_ERASE = 2'b10,
    ST_WAIT  = 2'b11
  } flc_op_t;

  typedef enum logic [1:0] {
    PH_OPC  = 2'b00,
    PH_ADDR = 2'b01,
    PH_DATA = 2'b10,
    PH_SKIP = 2'b11
  } flc_phase_t;

endpackage

// ===== flc_spi_host.sv
module flc_spi_host (
  output logic       sclk_o,
  output logic       cs_n_o,
  output logic       si_o,
  output logic       hold_n_o,
  input  wire logic  so_i,
  input  wire logic  so_oe_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       cpol;
  logic [7:0] rx;
  ////////////////////////////////////////
  // Idle bus, clock parked low
  initial
  begin
    cpol = 1'b0;
    rx = 8'h00;
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
    hold_n_o = 1'b1;
  end
  task automatic open_frame(input logic pol);
    cpol = pol;
    sclk_o = pol;
    #17 cs_n_o = 1'b0;
    #40;
  endtask
  task automatic shift(input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n; i--)
    begin
      sclk_o = 1'b0;
      si_o = b[i];
      // Latch what stands just before the rise
      #40 rx = {rx[6:0], (so_oe_i === 1'b1) ? so_i : 1'bx};
      sclk_o = 1'b1;
      #40;
    end
  endtask
  task automatic close_frame();
    #40 sclk_o = cpol;
    #20 cs_n_o = 1'b1;
    si_o = ~si_o;
    #100;
  endtask
  task automatic pause_toggle();
    sclk_o = 1'b0;
    #20 hold_n_o = 1'b0;
    #20;
    repeat (3)
    begin
      sclk_o = 1'b1;
      si_o = ~si_o;
      #40 sclk_o = 1'b0;
      #40;
    end
    hold_n_o = 1'b1;
    #20;
  endtask
endmodule

// ===== flc_sync.sv
module flc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_ff;

  // Two flops per bit; first stage feeds only the second
  for (genvar b = 0; b < W; b++)
  begin : g_bit
    always_ff @(posedge clk_i)
    begin
      meta_ff[b] <= d_i[b];
      q_o[b]     <= meta_ff[b];
    end
  end

endmodule
